/* File: verilog/ppp_pkg.sv */
// Purpose: Shared constants and carriers for the printer parallel port.
// Assumes: APB with 32-bit data; each register takes one aligned word.
// Notes:   Byte address of a register is four times its index.
package ppp_pkg;

   localparam int ADDR_W = 5;

   // Register indices; byte address is four times the index
   localparam logic [2:0] IDX_DATA = 3'h0;
   localparam logic [2:0] IDX_COND = 3'h1;
   localparam logic [2:0] IDX_CMD  = 3'h2;
   localparam logic [2:0] IDX_IST  = 3'h3;
   localparam logic [2:0] IDX_IMSK = 3'h4;
   localparam logic [2:0] IDX_LAST = IDX_IMSK;

   // Command register bit positions
   localparam int CMD_STROBE = 0;
   localparam int CMD_AUTOLF = 1;
   localparam int CMD_INIT_N = 2;
   localparam int CMD_SELIN  = 3;
   localparam int CMD_ACKIE  = 4;
   localparam int CMD_DIR    = 5;
   localparam int CMD_W      = 6;

   // Condition register bit positions
   localparam int COND_BUSY  = 7;
   localparam int COND_ACK_N = 6;
   localparam int COND_PEND  = 5;
   localparam int COND_SEL   = 4;
   localparam int COND_ERR_N = 3;

   // Interrupt event bit positions
   localparam int EVT_ACK  = 0;
   localparam int EVT_ERR  = 1;
   localparam int EVT_PEND = 2;
   localparam int EVT_W    = 3;

   // Values after reset, and the fixed low condition bits
   localparam logic [7:0]       DATA_RST = 8'h00;
   localparam logic [CMD_W-1:0] CMD_RST  = 6'h04;
   localparam logic [EVT_W-1:0] IMSK_RST = 3'h1;
   localparam logic [2:0]       COND_LOW = 3'h0;

   typedef struct packed {
      logic       busy;
      logic       ack_n;
      logic       paper_end;
      logic       selected;
      logic       error_n;
      logic [7:0] data_in;
   } ppp_pins_in_s;

   typedef struct packed {
      logic [7:0] data_out;
      logic       data_oe;
      logic       strobe_n;
      logic       auto_lf_n;
      logic       init_n;
      logic       select_in_n;
   } ppp_pins_out_s;

endpackage

/* File: verilog/ppp_evt.sv */
// Purpose: Sticky event flags, cleared by writing a one.
// Assumes: Set and clear are one-cycle qualified pulses.
// Notes:   A set in the clearing cycle wins, so no event is lost.
`timescale 1ns/10ps
module ppp_evt #(
   parameter int W = 3
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] set,
   input  wire logic         clr_en,
   input  wire logic [W-1:0] clr_bits,
   output      logic [W-1:0] flags
);

   typedef struct packed {
      logic [W-1:0] flag;
   } ppp_evt_s;

   ppp_evt_s st;
   ppp_evt_s next_st;

   always_comb begin
      next_st = st;
      for (int i = 0; i < W; i++) begin
         if (set[i]) begin
            next_st.flag[i] = 1'b1;
         end else if (clr_en && clr_bits[i]) begin
            next_st.flag[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign flags = st.flag;

endmodule

/* File: verilog/ppp_port.sv */
// What this block does
// - Write at data offset loads output latch; read returns latch contents, or the data inputs while command bit 5 is set.
// - Read at condition offset returns live printer handshake and condition inputs.
// - Write at command offset updates control latch; read returns latched bits 4 to 0.
// - Condition bit 7 shows busy; host waits while it is set.
// - Condition bit 6 shows the acknowledge input level.
// - Condition bit 5 reads one when paper has run out.
// - Condition bit 4 reads one when the printer is selected.
// - Condition bit 3 reads zero on printer error, else one.
// - Command bit 5 is write-only; one disables data drivers for input.
// - Command bit 4 enables interrupt on acknowledge rising edge; else none.
// - Command bit 3 set asserts select-in toward the printer.
// - Command bit 1 set asserts the auto line-feed output.
// - Eight data bits are presented in parallel to the peripheral.
//
// Purpose: Printer parallel port with APB register access.
// Assumes: Printer inputs are synchronous to pclk.
// Notes:   Reads are answered after one wait-free access phase.
`timescale 1ns/10ps
module ppp_port (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [ppp_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                pwdata,
   input  wire logic [3:0]                 pstrb,
   output      logic [31:0]                prdata,
   output      logic                       pready,
   output      logic                       pslverr,
   output      logic                       irq,
   input  wire ppp_pkg::ppp_pins_in_s      pins_in,
   output      ppp_pkg::ppp_pins_out_s     pins_out
);

   typedef struct packed {
      logic [7:0]                data_latch;
      logic [ppp_pkg::CMD_W-1:0] cmd;
      logic [ppp_pkg::EVT_W-1:0] imsk;
      logic                      ack_prev;
      logic                      err_prev;
      logic                      pend_prev;
      logic [31:0]               rdata;
      logic                      rerr;
   } ppp_state_s;

   ppp_state_s                st;
   ppp_state_s                next_st;
   logic [ppp_pkg::EVT_W-1:0] evt_set;
   logic [ppp_pkg::EVT_W-1:0] ist;
   logic                      acc;
   logic                      wr_ok;
   logic                      ist_clr;

   // Full decode: unaligned or out-of-range addresses answer with an error
   function automatic logic ppp_hit(input logic [ppp_pkg::ADDR_W-1:0] a);
      logic [ppp_pkg::ADDR_W-3:0] idx;
      idx = a[ppp_pkg::ADDR_W-1:2];
      return (a[1:0] == 2'h0) && (idx <= 3'(ppp_pkg::IDX_LAST));
   endfunction

   function automatic logic [2:0] ppp_idx(input logic [ppp_pkg::ADDR_W-1:0] a);
      return a[4:2];
   endfunction

   // Read data is captured in the setup phase so prdata comes from a flop
   function automatic logic [7:0] ppp_rd(input ppp_state_s s,
                                         input ppp_pkg::ppp_pins_in_s p,
                                         input logic [ppp_pkg::EVT_W-1:0] ev,
                                         input logic [2:0] idx);
      logic [7:0] v;
      v = 8'h00;
      unique case (idx)
         ppp_pkg::IDX_DATA: begin
            v = s.cmd[ppp_pkg::CMD_DIR] ? p.data_in : s.data_latch;
         end
         ppp_pkg::IDX_COND: begin
            v[ppp_pkg::COND_BUSY]  = p.busy;
            v[ppp_pkg::COND_ACK_N] = p.ack_n;
            v[ppp_pkg::COND_PEND]  = p.paper_end;
            v[ppp_pkg::COND_SEL]   = p.selected;
            v[ppp_pkg::COND_ERR_N] = p.error_n;
            v[2:0]                 = ppp_pkg::COND_LOW;
         end
         ppp_pkg::IDX_CMD: begin
            // Direction bit is write-only and reads as zero
            v[ppp_pkg::CMD_DIR-1:0] = s.cmd[ppp_pkg::CMD_DIR-1:0];
         end
         ppp_pkg::IDX_IST: begin
            v[ppp_pkg::EVT_W-1:0] = ev;
         end
         ppp_pkg::IDX_IMSK: begin
            v[ppp_pkg::EVT_W-1:0] = s.imsk;
         end
         default: begin
            v = 8'h00;
         end
      endcase
      return v;
   endfunction

   assign acc     = psel && penable;
   assign wr_ok   = acc && pwrite && pstrb[0] && ppp_hit(paddr);
   assign ist_clr = wr_ok && (ppp_idx(paddr) == ppp_pkg::IDX_IST);

   // Edge events; the acknowledge event needs its enable in the command latch
   always_comb begin
      evt_set                    = '0;
      evt_set[ppp_pkg::EVT_ACK]  = pins_in.ack_n && !st.ack_prev
                                   && st.cmd[ppp_pkg::CMD_ACKIE];
      evt_set[ppp_pkg::EVT_ERR]  = !pins_in.error_n && st.err_prev;
      evt_set[ppp_pkg::EVT_PEND] = pins_in.paper_end && !st.pend_prev;
   end

   ppp_evt #(
      .W (ppp_pkg::EVT_W)
   ) u_evt (
      .pclk     (pclk),
      .presetn  (presetn),
      .set      (evt_set),
      .clr_en   (ist_clr),
      .clr_bits (pwdata[ppp_pkg::EVT_W-1:0]),
      .flags    (ist)
   );

   always_comb begin
      next_st           = st;
      next_st.ack_prev  = pins_in.ack_n;
      next_st.err_prev  = pins_in.error_n;
      next_st.pend_prev = pins_in.paper_end;
      if (psel && !penable) begin
         next_st.rerr  = !ppp_hit(paddr);
         next_st.rdata = '0;
         if (!pwrite && ppp_hit(paddr)) begin
            next_st.rdata[7:0] = ppp_rd(st, pins_in, ist, ppp_idx(paddr));
         end
      end
      if (wr_ok) begin
         unique case (ppp_idx(paddr))
            ppp_pkg::IDX_DATA: begin
               next_st.data_latch = pwdata[7:0];
            end
            ppp_pkg::IDX_CMD: begin
               next_st.cmd = pwdata[ppp_pkg::CMD_W-1:0];
            end
            ppp_pkg::IDX_IMSK: begin
               next_st.imsk = pwdata[ppp_pkg::EVT_W-1:0];
            end
            default: begin
               next_st.imsk = st.imsk;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st.data_latch <= ppp_pkg::DATA_RST;
         st.cmd        <= ppp_pkg::CMD_RST;
         st.imsk       <= ppp_pkg::IMSK_RST;
         st.ack_prev   <= 1'b1;
         st.err_prev   <= 1'b1;
         st.pend_prev  <= 1'b0;
         st.rdata      <= '0;
         st.rerr       <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // Zero-wait access phase; read data was prepared during setup
   assign pready  = 1'b1;
   assign prdata  = st.rdata;
   assign pslverr = acc && st.rerr;

   // Interrupt needs both the acknowledge enable and an unmasked flag
   assign irq = st.cmd[ppp_pkg::CMD_ACKIE] && |(ist & st.imsk);

   always_comb begin
      pins_out.data_out    = st.data_latch;
      pins_out.data_oe     = !st.cmd[ppp_pkg::CMD_DIR];
      pins_out.strobe_n    = !st.cmd[ppp_pkg::CMD_STROBE];
      pins_out.auto_lf_n   = !st.cmd[ppp_pkg::CMD_AUTOLF];
      pins_out.init_n      = st.cmd[ppp_pkg::CMD_INIT_N];
      pins_out.select_in_n = !st.cmd[ppp_pkg::CMD_SELIN];
   end

endmodule

/* File: dv/ppp_monitor.sv */
// Purpose: Assertions on the printer port bus and pins.
// Assumes: Bound to ppp_port by the bench.
// Notes:   Tracks the interrupt enable itself, since cmd is internal.
`timescale 1ns/10ps
module ppp_monitor (
   input wire logic                       pclk,
   input wire logic                       presetn,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [ppp_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0]                pwdata,
   input wire logic [3:0]                 pstrb,
   input wire logic [31:0]                prdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   input wire logic                       irq,
   input wire ppp_pkg::ppp_pins_in_s      pins_in,
   input wire ppp_pkg::ppp_pins_out_s     pins_out
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic ie;
   wire  wr = psel && penable && pwrite && pstrb[0];
   wire  rd = psel && penable && !pwrite;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) ie <= 1'b0;
      else if (wr && paddr == 5'h08) ie <= pwdata[4];
   AST_DATA_OUT: assert property (wr && paddr == 5'h00 |=>
      pins_out.data_out == $past(pwdata[7:0])) else $error("data latch wrong");
   AST_DATA_RD: assert property (rd && paddr == 5'h00 && $past(pins_out.data_oe) |->
      prdata == {24'h0, $past(pins_out.data_out)}) else $error("data readback wrong");
   AST_COND: assert property (rd && paddr == 5'h04 |->
      prdata == {24'h0, $past(pins_in[12:8]), 3'h0}) else $error("condition wrong");
   AST_CMD_PINS: assert property (wr && paddr == 5'h08 |=>
      {pins_out.strobe_n, pins_out.auto_lf_n, pins_out.select_in_n} == ~$past({pwdata[0], pwdata[1], pwdata[3]}))
      else $error("command pins wrong");
   AST_INIT: assert property (wr && paddr == 5'h08 |=> pins_out.init_n == $past(pwdata[2]))
      else $error("init pin wrong");
   AST_DIR: assert property (wr && paddr == 5'h08 |=> pins_out.data_oe != $past(pwdata[5]))
      else $error("direction wrong");
   AST_IRQ_OFF: assert property (!ie |-> !irq) else $error("irq while disabled");
   AST_RESET: assert property ($rose(presetn) |-> pins_out.data_out == 8'h00 &&
      pins_out.data_oe && pins_out.strobe_n && !irq) else $error("reset state wrong");
endmodule

/* File: dv/ppp_printer.sv */
// Purpose: Behavioural printer on the far side of the port.
// Assumes: Pins sampled on pclk; ACK_CYC cycles of 50 ns.
// Notes:   Busy ends as acknowledge returns high.
`timescale 1ns/10ps
module ppp_printer #(
   parameter int ACK_CYC = 100
) (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire ppp_pkg::ppp_pins_out_s pins_out,
   input  wire logic                   paper_end,
   input  wire logic                   selected,
   input  wire logic                   error_n,
   input  wire logic [7:0]             ext_val,
   output      ppp_pkg::ppp_pins_in_s  pins_in,
   output      logic [7:0]             got
);
   logic       busy, ack_n, stb_q;
   logic [7:0] cnt;
   // Released data lines show the far driver, never a stale latch
   assign pins_in = {busy, ack_n, paper_end, selected, error_n,
                     pins_out.data_oe ? pins_out.data_out : ext_val};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {busy, cnt, got} <= '0;
         {ack_n, stb_q} <= 2'h3;
      end else begin
         stb_q <= pins_out.strobe_n;
         if (!stb_q && pins_out.strobe_n) begin
            busy <= 1'b1;
            got <= pins_out.data_out;
            cnt <= 8'(ACK_CYC + 1);
         end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
            ack_n <= (cnt == 8'h01);
            busy <= (cnt != 8'h01);
         end
      end
   end
endmodule

/* File: dv/test_printer_parallel_port.sv */
// Purpose: Self-checking bench for the printer port.
// Assumes: Zero-wait APB slave; printer model on the pins.
// Notes:   Random values from a fixed LFSR seed.
`timescale 1ns/10ps
module test_printer_parallel_port;
   logic [31:0] pwdata = '0, rd, seed = 32'h142EE;
   logic [7:0]  ext = 8'h00, got, c;
   logic [4:0]  paddr = '0;
   logic [3:0]  strb = 4'hF;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        pready, pslverr, irq, e, saw, pe = 0, sel = 1, err_n = 1;
   int          fail_count = 0, compares = 0, n;
   ppp_pkg::ppp_pins_in_s  pins_in;
   ppp_pkg::ppp_pins_out_s pins_out;
   always #25 pclk = ~pclk;
   ppp_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(rd), .pready(pready), .pslverr(pslverr),
      .irq(irq), .pins_in(pins_in), .pins_out(pins_out));
   ppp_printer u_prn (.pclk(pclk), .presetn(presetn), .pins_out(pins_out), .paper_end(pe),
      .selected(sel), .error_n(err_n), .ext_val(ext), .pins_in(pins_in), .got(got));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic results;
      $display("fails %0d compares %0d", fail_count, compares);
      if (fail_count == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s exp %h seen %h", s, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++k < 20);
      e = pslverr;
      {psel, penable} <= 2'h0;
      if (k >= 20) begin
         fail_count++;
         results;
      end
   endtask
   task automatic rdchk(input logic [4:0] a, input logic [31:0] exp, input string s);
      apb(0, a, 0);
      chk(s, rd, exp);
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(5'h00, 32'h00, "data rst");
      rdchk(5'h08, 32'h04, "cmd rst");
      rdchk(5'h10, 32'h01, "mask rst");
      $display("reset test done");
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         apb(1, 5'h00, seed);
         rdchk(5'h00, {24'h0, seed[7:0]}, "data");
         c = 8'h04 ^ (8'h01 << i);
         apb(1, 5'h08, {24'h0, c});
         rdchk(5'h08, {24'h0, c & 8'h1F}, "cmd");
         chk("pins", pins_out[4:0], {~c[5], ~c[0], ~c[1], c[2], ~c[3]});
      end
      ext <= seed[15:8];
      rdchk(5'h00, {24'h0, seed[15:8]}, "data in");
      apb(1, 5'h08, 32'h00);
      repeat (1000) @(posedge pclk);
      apb(1, 5'h08, 32'h04);
      $display("command test done");
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         {pe, sel, err_n} <= seed[2:0];
         rdchk(5'h04, {24'h0, 2'b01, seed[2:0], 3'h0}, "cond");
      end
      for (int j = 0; j < 3; j++) begin
         c = (j == 2) ? 8'h04 : 8'h14;
         apb(1, 5'h08, {24'h0, c});
         apb(1, 5'h10, (j == 1) ? 32'h0 : 32'h1);
         apb(1, 5'h0C, 32'h7);
         seed = lfsr(seed);
         apb(1, 5'h00, seed);
         apb(1, 5'h08, {24'h0, c | 8'h01});
         repeat (10) @(posedge pclk);
         apb(1, 5'h08, {24'h0, c});
         saw = 0;
         // No new character until busy clears
         for (n = 0; n < 300; n++) begin
            apb(0, 5'h04, 0);
            if (!rd[6]) saw = 1;
            if (!rd[7]) break;
         end
         if (n == 300) begin
            fail_count++;
            results;
         end
         @(posedge pclk);
         chk("ack seen", saw, 1);
         chk("got", got, seed[7:0]);
         chk("irq", irq, j == 0);
         rdchk(5'h0C, {31'h0, j != 2}, "event");
         apb(1, 5'h0C, 32'h1);
         // The clear lands on the edge the task returns at; look one edge later
         @(posedge pclk);
         chk("irq clr", irq, 0);
      end
      $display("print test done");
      apb(0, 5'h14, 0);
      chk("slverr", e, 1);
      chk("bad rd", rd, 0);
      strb <= 4'h0;
      apb(1, 5'h00, ~seed);
      strb <= 4'hF;
      rdchk(5'h00, {24'h0, seed[7:0]}, "strb off");
      $display("error test done");
      results;
   end
endmodule
bind ppp_port ppp_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .irq(irq), .pins_in(pins_in), .pins_out(pins_out));
